/* logic/mmu_unit.sv */
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module mmu_unit #(
  parameter int unsigned SLOW_CYC = mmu_pkg::SLOW_TO_CYC,
  parameter int unsigned FAST_CYC = mmu_pkg::FAST_TO_CYC,
  parameter logic        BUS_OPT  = 1'b1,
  parameter logic        CAL_MEM  = 1'b1,
  parameter logic [4:0]  MOD_FIT  = 5'h01
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic [mmu_pkg::NKEYS-1:0] key_pins,
  input  wire logic                 pin_cal,
  input  wire logic                 adc_valid,
  input  wire logic signed [23:0]   adc_data,
  output logic signed [31:0]        disp_value,
  output logic                      disp_update,
  output mmu_pkg::mmu_status_t      status
);
  // ------------------------------------------------------------
  // synchronisers and key edge capture
  // ------------------------------------------------------------
  logic [mmu_pkg::NKEYS-1:0] key_s1_r, key_s2_r, key_d_r;
  logic cal_s1_r, cal_s2_r, cal_d_r;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      key_s1_r <= '0;
      key_s2_r <= '0;
      key_d_r  <= '0;
      cal_s1_r <= 1'b0;
      cal_s2_r <= 1'b0;
      cal_d_r  <= 1'b0;
    end
    else
    begin
      key_s1_r <= key_pins;
      key_s2_r <= key_s1_r;
      key_d_r  <= key_s2_r;
      cal_s1_r <= pin_cal;
      cal_s2_r <= cal_s1_r;
      cal_d_r  <= cal_s2_r;
    end

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic       dp_wr_r, dp_rd_r;
  logic [7:0] dp_addr_r;
  logic [mmu_pkg::NKEYS-1:0] swkey;
  logic [2:0] sw_func;
  logic [4:0] sw_rate;
  logic [2:0] sw_filt;
  logic wr_scale, wr_offs, wr_limhi, wr_limlo, wr_setup;
  wire  take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      dp_wr_r   <= 1'b0;
      dp_rd_r   <= 1'b0;
      dp_addr_r <= 8'h00;
    end
    else
    begin
      dp_wr_r   <= take && hwrite;
      dp_rd_r   <= take && !hwrite;
      dp_addr_r <= haddr;
    end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign swkey    = (dp_wr_r && dp_addr_r == mmu_pkg::A_KEY) ? hwdata[mmu_pkg::NKEYS-1:0] : '0;
  assign wr_scale = dp_wr_r && dp_addr_r == mmu_pkg::A_SCALE;
  assign wr_offs  = dp_wr_r && dp_addr_r == mmu_pkg::A_OFFS;
  assign wr_limhi = dp_wr_r && dp_addr_r == mmu_pkg::A_LIMHI;
  assign wr_limlo = dp_wr_r && dp_addr_r == mmu_pkg::A_LIMLO;
  assign wr_setup = dp_wr_r && dp_addr_r == mmu_pkg::A_SETUP;
  assign sw_func  = hwdata[2:0];
  assign sw_rate  = hwdata[8:4];
  assign sw_filt  = hwdata[14:12];

  // one pulse per press whether panel or software [RL1]
  logic [mmu_pkg::NKEYS-1:0] kraw, kev;
  logic remote_r;
  assign kraw = (key_s2_r & ~key_d_r) | swkey;
  // remote lockout keeps only the remote key [RL16]
  assign kev  = remote_r ? (kraw & (mmu_pkg::NKEYS'(1) << mmu_pkg::K_REMOTE)) : kraw;
  wire cal_enter = cal_s2_r && !cal_d_r;

  // ------------------------------------------------------------
  // function, range, modifiers
  // ------------------------------------------------------------
  mmu_pkg::mmu_func_t   func_r;
  mmu_pkg::mmu_filter_t filt_r;
  logic [2:0] range_r;
  logic [4:0] rate_r;
  logic       xdig_r;
  wire  func_chg = kev[mmu_pkg::K_FUNC];
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      func_r  <= mmu_pkg::FN_VDC;             // [RL22]
      range_r <= mmu_pkg::RANGE_TOP;          // [RL22]
      rate_r  <= mmu_pkg::RATE_RESET;         // [RL22]
      filt_r  <= mmu_pkg::FLT_FAST;           // [RL22]
      xdig_r  <= 1'b0;
    end
    else
    begin
      if (func_chg)
        func_r <= mmu_pkg::mmu_func_t'(sw_func);
      // five dc decade ranges [RL20]
      if (kev[mmu_pkg::K_RANGUP] && range_r != mmu_pkg::RANGE_TOP)
        range_r <= range_r + 3'h1;
      else if (kev[mmu_pkg::K_RANGDN] && range_r != 3'h0)
        range_r <= range_r - 3'h1;
      if (kev[mmu_pkg::K_SAMPLE])            // [RL23]
        rate_r <= (rate_r == mmu_pkg::RATE_ALT) ? mmu_pkg::RATE_RESET : mmu_pkg::RATE_ALT;
      else if (wr_setup && !remote_r && sw_rate <= mmu_pkg::RATE_MAX)
        rate_r <= sw_rate;
      if (kev[mmu_pkg::K_FILTER])             // [RL2]
        filt_r <= (filt_r == mmu_pkg::FLT_SLOW_TIMED || filt_r == mmu_pkg::FLT_SLOW)
                  ? mmu_pkg::FLT_FAST : mmu_pkg::FLT_SLOW;
      else if (wr_setup && !remote_r && sw_filt <= 3'h4)
        filt_r <= mmu_pkg::mmu_filter_t'(sw_filt);
      if (kev[mmu_pkg::K_XDIGIT])
        xdig_r <= !xdig_r;
    end

  // ------------------------------------------------------------
  // remote control
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      remote_r <= 1'b0;                       // [RL18]
    else if (kraw[mmu_pkg::K_REMOTE])        // a software request may also enter remote
      remote_r <= (BUS_OPT && !swkey[mmu_pkg::K_REMOTE]) ? 1'b0 : !remote_r; // [RL17]

  // ------------------------------------------------------------
  // math mode enables and factors
  // ------------------------------------------------------------
  logic lim_on_r, pk_on_r, off_on_r, scl_on_r, ext_on_r;
  logic signed [31:0] scale_r, offs_r, limhi_r, limlo_r;
  wire  math_off = func_chg || cal_enter;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      lim_on_r <= 1'b0;
      pk_on_r  <= 1'b0;
      off_on_r <= 1'b0;
      scl_on_r <= 1'b0;
      ext_on_r <= 1'b0;
    end
    else if (math_off)                         // [RL15] [RL11]
    begin
      lim_on_r <= 1'b0;
      pk_on_r  <= 1'b0;
      off_on_r <= 1'b0;
      scl_on_r <= 1'b0;
      ext_on_r <= 1'b0;
    end
    else
    begin
      // only the keys toggle modes, never a store [RL8]
      lim_on_r <= lim_on_r ^ kev[mmu_pkg::K_LIMITS];
      pk_on_r  <= pk_on_r  ^ kev[mmu_pkg::K_PEAK];
      off_on_r <= off_on_r ^ kev[mmu_pkg::K_OFFSET];
      scl_on_r <= scl_on_r ^ kev[mmu_pkg::K_SCALE];
      ext_on_r <= ext_on_r ^ kev[mmu_pkg::K_EXTREF];
    end

  // factors are kept across mode changes, lost only on reset [RL15]
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      scale_r <= 32'sh00000001;
      offs_r  <= 32'sh00000000;
      limhi_r <= 32'sh00000000;
      limlo_r <= 32'sh00000000;
    end
    else if (!remote_r)
    begin
      if (wr_scale && hwdata != 32'h00000000)
        scale_r <= hwdata;
      if (wr_offs)
        offs_r <= hwdata;
      if (wr_limhi)
        limhi_r <= hwdata;                     // [RL11]
      if (wr_limlo)
        limlo_r <= hwdata;
    end

  // ------------------------------------------------------------
  // settling time-out
  // ------------------------------------------------------------
  logic [31:0] settle_r;
  logic        settle_req;
  logic        rd_done;
  wire  timed = filt_r == mmu_pkg::FLT_SLOW_TIMED || filt_r == mmu_pkg::FLT_FAST_TIMED;
  wire [31:0] to_len = (filt_r == mmu_pkg::FLT_SLOW || filt_r == mmu_pkg::FLT_SLOW_TIMED)
                       ? SLOW_CYC : ((filt_r == mmu_pkg::FLT_BYPASS) ? 32'h1 : FAST_CYC);
  assign settle_req = func_chg || kev[mmu_pkg::K_RANGUP] || kev[mmu_pkg::K_RANGDN]; // [RL3]
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      settle_r <= 32'h0;
    else if (settle_req || (rd_done && timed)) // [RL3] [RL4]
      settle_r <= to_len;
    else if (settle_r != 32'h0)
      settle_r <= settle_r - 32'h1;
  wire settling = settle_r != 32'h0;

  // ------------------------------------------------------------
  // averager
  // ------------------------------------------------------------
  logic signed [48:0] acc_r;
  logic        [17:0] cnt_r;
  logic signed [31:0] avg;
  wire  [17:0] need = 18'h1 << rate_r;                // [RL5]
  assign rd_done = adc_valid && !settling && (cnt_r + 18'h1 >= need); // lowered rate ends it
  assign avg = 32'(($signed(acc_r) + $signed(adc_data)) >>> rate_r); // [RL24]
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      acc_r <= '0;
      cnt_r <= '0;
    end
    else if (settling || settle_req || rd_done)
    begin
      acc_r <= '0;
      cnt_r <= '0;
    end
    else if (adc_valid)
    begin
      acc_r <= acc_r + 49'(adc_data);
      cnt_r <= cnt_r + 18'h1;
    end

  // ------------------------------------------------------------
  // math pipe: ratio, scale then offset
  // ------------------------------------------------------------
  logic signed [31:0] ref_r, ratio_r, y_r;
  logic               s1_r, s2_r;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ref_r <= 32'sh00000001;
    else if (rd_done && kev[mmu_pkg::K_EXTREF] == 1'b0 && key_s2_r[mmu_pkg::K_EXTREF] && avg != 0)
      ref_r <= avg;                              // held key measures the reference
  wire signed [31:0] div_by = ext_on_r ? ref_r : (scl_on_r ? scale_r : 32'sh00000001);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ratio_r <= '0;
      y_r     <= '0;
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
    end
    else
    begin
      s1_r    <= rd_done;
      s2_r    <= s1_r;
      if (rd_done)
        ratio_r <= avg / div_by;                 // [RL6] [RL7]
      if (s1_r)
        y_r <= off_on_r ? ratio_r - offs_r : ratio_r; // [RL21] [RL7]
    end

  // ------------------------------------------------------------
  // display, limits, peaks
  // ------------------------------------------------------------
  mmu_pkg::mmu_limit_t lim_r;
  logic signed [31:0] pkhi_r, pklo_r, calf_r;
  logic pk_first_r;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      disp_value  <= '0;
      disp_update <= 1'b0;
      lim_r       <= mmu_pkg::LIM_PASS;
    end
    else
    begin
      disp_update <= s2_r;                         // [RL24]
      if (s2_r)
      begin
        disp_value <= y_r;
        if (y_r > limhi_r)                         // [RL9] [RL10]
          lim_r <= mmu_pkg::LIM_HI;
        else if (y_r < limlo_r)
          lim_r <= mmu_pkg::LIM_LO;
        else
          lim_r <= mmu_pkg::LIM_PASS;
      end
    end
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pkhi_r     <= '0;
      pklo_r     <= '0;
      pk_first_r <= 1'b1;
    end
    else if (kev[mmu_pkg::K_PEAK] && !pk_on_r && !math_off) // [RL12]
    begin
      pkhi_r     <= '0;
      pklo_r     <= '0;
      pk_first_r <= 1'b1;
    end
    else if (s2_r && pk_on_r)
    begin
      pk_first_r <= 1'b0;
      if (pk_first_r || y_r > pkhi_r)
        pkhi_r <= y_r;
      if (pk_first_r || y_r < pklo_r)
        pklo_r <= y_r;
    end

  // store in cal mode with cal memory overwrites the single cal factor with last reading [RL13]
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      calf_r <= '0;
    else if (CAL_MEM && cal_s2_r && kev[mmu_pkg::K_STORE])
      calf_r <= disp_value;

  // ------------------------------------------------------------
  // status and read mux
  // ------------------------------------------------------------
  wire mod_missing = !MOD_FIT[func_r];
  always_comb
  begin
    status             = '0;
    status.remote      = remote_r;
    status.cal         = cal_s2_r;
    status.extra_digit = cal_s2_r || xdig_r;     // [RL14]
    status.show_ovr    = !cal_s2_r;              // [RL14]
    status.err         = (mod_missing && !cal_s2_r) ? mmu_pkg::ERR_MODULE : 4'h0; // [RL19]
    status.limit       = lim_r;
    status.limits_on   = lim_on_r;
    status.peak_on     = pk_on_r;
    status.offset_on   = off_on_r;
    status.scale_on    = scl_on_r;
    status.extref_on   = ext_on_r;
    status.filter      = filt_r;
    status.rate        = rate_r;
    status.func        = func_r;
    status.range       = range_r;
  end
  always_comb
  begin
    hrdata = 32'h00000000;
    if (dp_rd_r)
      unique case (dp_addr_r)
        mmu_pkg::A_SCALE:  hrdata = scale_r;
        mmu_pkg::A_OFFS:   hrdata = offs_r;
        mmu_pkg::A_LIMHI:  hrdata = limhi_r;
        mmu_pkg::A_LIMLO:  hrdata = limlo_r;
        mmu_pkg::A_STAT:   hrdata = 32'(status);
        mmu_pkg::A_RESULT: hrdata = disp_value;
        mmu_pkg::A_PKHI:   hrdata = pkhi_r;
        mmu_pkg::A_PKLO:   hrdata = pklo_r;
        mmu_pkg::A_CALF:   hrdata = calf_r;
        mmu_pkg::A_SETUP:  hrdata = {17'h0, filt_r, 3'h0, rate_r, 4'h0};
        default:           hrdata = 32'h00000000;
      endcase
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_remote_lock: assert property (@(posedge hclk) disable iff (!hresetn) // [RL16]
    remote_r |-> (kev & ~(mmu_pkg::NKEYS'(1) << mmu_pkg::K_REMOTE)) == '0)
    else $error("key passed while remote");
  a_local_only: assert property (@(posedge hclk) disable iff (!hresetn) // [RL17]
    BUS_OPT && !remote_r && !swkey[mmu_pkg::K_REMOTE] |=> !remote_r)
    else $error("panel entered remote");
  a_math_clear: assert property (@(posedge hclk) disable iff (!hresetn) // [RL15]
    math_off |=> !lim_on_r && !pk_on_r && !off_on_r && !scl_on_r && !ext_on_r)
    else $error("math mode survived function change");
  a_store_noen: assert property (@(posedge hclk) disable iff (!hresetn) // [RL8]
    wr_scale && !kev[mmu_pkg::K_SCALE] |=> scl_on_r == $past(scl_on_r) || $past(math_off))
    else $error("store enabled scaling");
  a_limit_hi: assert property (@(posedge hclk) disable iff (!hresetn) // [RL9]
    s2_r && y_r > limhi_r |=> lim_r == mmu_pkg::LIM_HI)
    else $error("limit HI wrong");
  a_pipe_update: assert property (@(posedge hclk) disable iff (!hresetn) // [RL24]
    rd_done |-> ##3 disp_update)
    else $error("no update after reading");
  a_settle_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [RL3]
    settle_req |=> !rd_done)
    else $error("reading during settling");
  a_cal_err: assert property (@(posedge hclk) disable iff (!hresetn) // [RL14]
    cal_s2_r |-> status.err == 4'h0 && !status.show_ovr)
    else $error("error shown in cal mode");
endmodule
`default_nettype wire

/* logic/mmu_pkg.sv */
// Function
// RL1 - each held key press is taken exactly once
// RL2 - five filter settings, slow and fast timed ones with 550 and 50 ms
// RL3 - settling time-out before first reading after function or range change
// RL4 - timed filters insert settling before every later reading
// RL5 - rate n averages 2^n samples per reading
// RL6 - external reference mode divides input by reference reading
// RL7 - display value is input divided by scale, minus offset
// RL8 - storing a factor never enables its math mode
// RL9 - limits give HI above high, LO below low, PASS between inclusive
// RL10 - limit compare uses final value after scaling and offset
// RL11 - one limit pair kept; function change leaves limits mode
// RL12 - peak tracks max and min, kept when off, cleared on reset or re-entry
// RL13 - store in cal mode with cal memory saves reading and erases factors; code keeps scale, offset and limits
// RL14 - cal mode shows extra digit, hides error codes and overrange
// RL15 - function change or cal entry turns math modes off, keeps factors
// RL16 - in remote only remote key and power have effect; code lets a held ext ref key set the reference and cal entry clear math modes
// RL17 - with bus option fitted remote key only returns to local
// RL18 - power reset forces local control
// RL19 - function with absent module shows error nine
// RL20 - dc volts has five decade ranges 100 mV to 1000 V
// RL21 - scaling applied before offset
// RL22 - reset gives dc volts, 1000 V, rate 7, fast filter, math off
// RL23 - sample key toggles rate between 5 and 7
// RL24 - sum of 2^n samples shifted right by n, one update per reading
`default_nettype none
package mmu_pkg;
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned SLOW_TO_MS   = 550;
  localparam int unsigned FAST_TO_MS   = 50;
  localparam int unsigned SLOW_TO_CYC  = SLOW_TO_MS * 1000 * CLK_MHZ;
  localparam int unsigned FAST_TO_CYC  = FAST_TO_MS * 1000 * CLK_MHZ;
  localparam logic [4:0]  RATE_RESET   = 5'h07;
  localparam logic [4:0]  RATE_ALT     = 5'h05;
  localparam logic [4:0]  RATE_MAX     = 5'h11;
  localparam logic [2:0]  RANGE_TOP    = 3'h4;
  localparam logic [3:0]  ERR_MODULE   = 4'h9;
  // register byte addresses
  localparam logic [7:0]  A_CTRL   = 8'h00;
  localparam logic [7:0]  A_KEY    = 8'h04;
  localparam logic [7:0]  A_SCALE  = 8'h08;
  localparam logic [7:0]  A_OFFS   = 8'h0C;
  localparam logic [7:0]  A_LIMHI  = 8'h10;
  localparam logic [7:0]  A_LIMLO  = 8'h14;
  localparam logic [7:0]  A_STAT   = 8'h18;
  localparam logic [7:0]  A_RESULT = 8'h1C;
  localparam logic [7:0]  A_PKHI   = 8'h20;
  localparam logic [7:0]  A_PKLO   = 8'h24;
  localparam logic [7:0]  A_CALF   = 8'h28;
  localparam logic [7:0]  A_SETUP  = 8'h2C;

  typedef enum logic [2:0] {
    FLT_SLOW, FLT_FAST, FLT_BYPASS, FLT_SLOW_TIMED, FLT_FAST_TIMED
  } mmu_filter_t;
  typedef enum logic [2:0] {FN_VDC, FN_VAC, FN_ADC, FN_AAC, FN_OHM} mmu_func_t;
  typedef enum logic [1:0] {LIM_PASS, LIM_HI, LIM_LO} mmu_limit_t;

  // key bits in the key pulse register
  localparam int K_SAMPLE = 0;
  localparam int K_FILTER = 1;
  localparam int K_REMOTE = 2;
  localparam int K_LIMITS = 3;
  localparam int K_PEAK   = 4;
  localparam int K_OFFSET = 5;
  localparam int K_SCALE  = 6;
  localparam int K_EXTREF = 7;
  localparam int K_STORE  = 8;
  localparam int K_RANGUP = 9;
  localparam int K_RANGDN = 10;
  localparam int K_XDIGIT = 11;
  localparam int K_FUNC   = 12;
  localparam int NKEYS    = 13;

  typedef struct packed {
    logic        remote;
    logic        cal;
    logic        extra_digit;
    logic        show_ovr;
    logic [3:0]  err;
    mmu_limit_t  limit;
    logic        limits_on;
    logic        peak_on;
    logic        offset_on;
    logic        scale_on;
    logic        extref_on;
    mmu_filter_t filter;
    logic [4:0]  rate;
    mmu_func_t   func;
    logic [2:0]  range;
  } mmu_status_t;
endpackage
`default_nettype wire

/* tb/mmu_far.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// front panel keys and converter sample stream
// ------------------------------------------------
module mmu_far (
  input  wire logic                      hclk,
  input  wire logic signed [23:0]        level,
  output logic [mmu_pkg::NKEYS-1:0]      key_pins,
  output logic                           adc_valid,
  output logic signed [23:0]             adc_data
);
  logic [1:0] ph;

  initial
  begin
    key_pins = '0;
    adc_valid = 1'b0;
    adc_data = '0;
    ph = 2'h0;
  end

  // a sample every other cycle, level and level+2 in turn; junk between strobes
  always @(posedge hclk)
  begin
    ph <= ph + 2'h1;
    adc_valid <= ph[0];
    adc_data <= ph[0] ? level + {22'h0, ph[1], 1'b0} : ~adc_data;
  end

  // key held closed for n cycles, then left open to settle
  task automatic press(input int k, input int n);
    @(posedge hclk);
    key_pins[k] <= 1'b1;
    repeat (n) @(posedge hclk);
    key_pins[k] <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                         hclk;
  logic                         hresetn;
  logic                         hsel;
  logic [7:0]                   haddr;
  logic [1:0]                   htrans;
  logic                         hwrite;
  logic [2:0]                   hsize;
  logic [31:0]                  hwdata;
  logic                         hready;
  logic [31:0]                  hrdata;
  logic                         hreadyout;
  logic                         hresp;
  logic [mmu_pkg::NKEYS-1:0]    key_pins;
  logic                         pin_cal;
  logic                         adc_valid;
  logic signed [23:0]           adc_data;
  logic signed [23:0]           level;
  logic signed [31:0]           disp_value;
  logic                         disp_update;
  mmu_pkg::mmu_status_t         status;
  logic [31:0]                  hr_s;
  logic [31:0]                  rd;
  logic                         rdy_s;
  logic                         upd_s;
  int                           g;
  int                           g0;
  int                           num_errors;
  int                           comparisons;

  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;

  // -----------------------------
  // sampling and helpers
  // -----------------------------
  // mid-cycle copies equal what the next rising edge samples
  always @(negedge hclk)
  begin
    hr_s = hrdata;
    rdy_s = hreadyout;
    upd_s = disp_update;
  end

  mmu_unit #(.SLOW_CYC(20), .FAST_CYC(5)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .key_pins(key_pins), .pin_cal(pin_cal), .adc_valid(adc_valid),
    .adc_data(adc_data), .disp_value(disp_value), .disp_update(disp_update),
    .status(status));

  mmu_far u_far (.hclk(hclk), .level(level), .key_pins(key_pins),
    .adc_valid(adc_valid), .adc_data(adc_data));

  task automatic wrap_up;
    $display("errors %0d of %0d compares", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus_wait;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (rdy_s !== 1'b1 && n < 50);
    if (rdy_s !== 1'b1)
    begin
      num_errors++;
      wrap_up();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    bus_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait();
    rd = hr_s;
  endtask

  task automatic key(input int k, input logic [31:0] x);
    bus(1'b1, mmu_pkg::A_KEY, (32'h1 << k) | x);
    repeat (4) @(posedge hclk);
  endtask

  task automatic wait_upd(input int k, output int n);
    n = 0;
    while (k > 0 && n < 5000)
    begin
      @(posedge hclk);
      n++;
      if (upd_s === 1'b1)
        k--;
    end
    if (k > 0)
    begin
      num_errors++;
      wrap_up();
    end
  endtask

  // -----------------------------
  // scenarios
  // -----------------------------
  task automatic t_reset;
    chk(32'(status.func), 32'(mmu_pkg::FN_VDC));
    chk(32'(status.rate), 32'(mmu_pkg::RATE_RESET));
    chk(32'(status.filter), 32'(mmu_pkg::FLT_FAST));
    chk({28'h0, status.limits_on, status.peak_on, status.offset_on, status.scale_on}, 0);
    chk(32'(status.remote), 32'h0);
    bus(1'b0, mmu_pkg::A_SCALE, 0);
    chk(rd, 32'h1);
    bus(1'b0, 8'h30, 0);
    chk(rd, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      key(i < 1 ? mmu_pkg::K_RANGUP : mmu_pkg::K_RANGDN, 0);
      chk(32'(status.range), i < 1 ? 4 : (i > 4 ? 0 : 4 - i));
    end
    key(mmu_pkg::K_RANGUP, 0);
  endtask

  task automatic t_keys;
    for (int i = 0; i < 3; i++)
    begin
      u_far.press(mmu_pkg::K_SAMPLE, 40);
      chk(32'(status.rate), i == 1 ? 32'h7 : 32'h5);
    end
    wait_upd(2, g);
    chk(disp_value, 32'd400);
  endtask

  task automatic t_filter;
    for (int f = 0; f < 5; f++)
    begin
      bus(1'b1, mmu_pkg::A_SETUP, {17'h0, f[2:0], 3'h0, 5'h5, 4'h0});
      bus(1'b0, mmu_pkg::A_SETUP, 0);
      chk(rd, {17'h0, f[2:0], 3'h0, 5'h5, 4'h0});
      chk(32'(status.filter), 32'(f));
    end
    bus(1'b1, mmu_pkg::A_SETUP, 32'h1050);
    wait_upd(2, g);
    wait_upd(1, g0);
    bus(1'b1, mmu_pkg::A_SETUP, 32'h4050);
    wait_upd(2, g);
    wait_upd(1, g);
    // a five-cycle time-out swallows two two-cycle sample slots
    chk(g, g0 + 4);
    bus(1'b1, mmu_pkg::A_SETUP, 32'h1050);
  endtask

  task automatic t_peak;
    key(mmu_pkg::K_PEAK, 0);
    wait_upd(2, g);
    level <= 24'sd499;
    wait_upd(2, g);
    key(mmu_pkg::K_PEAK, 0);
    level <= 24'sd399;
    bus(1'b0, mmu_pkg::A_PKHI, 0);
    chk(rd, 32'd500);
    bus(1'b0, mmu_pkg::A_PKLO, 0);
    chk(rd, 32'd400);
  endtask

  task automatic t_math;
    bus(1'b1, mmu_pkg::A_SCALE, 32'd4);
    bus(1'b1, mmu_pkg::A_OFFS, 32'd3);
    wait_upd(2, g);
    chk(disp_value, 32'd400);
    key(mmu_pkg::K_SCALE, 0);
    key(mmu_pkg::K_OFFSET, 0);
    wait_upd(2, g);
    chk(disp_value, 32'd97);
    bus(1'b1, mmu_pkg::A_LIMHI, 32'd97);
    bus(1'b1, mmu_pkg::A_LIMLO, 32'd97);
    key(mmu_pkg::K_LIMITS, 0);
    wait_upd(2, g);
    chk(32'(status.limit), 32'(mmu_pkg::LIM_PASS));
    bus(1'b1, mmu_pkg::A_LIMLO, 32'd98);
    wait_upd(2, g);
    chk(32'(status.limit), 32'(mmu_pkg::LIM_LO));
    bus(1'b1, mmu_pkg::A_LIMHI, 32'd96);
    bus(1'b1, mmu_pkg::A_LIMLO, 32'd90);
    wait_upd(2, g);
    chk(32'(status.limit), 32'(mmu_pkg::LIM_HI));
    u_far.press(mmu_pkg::K_EXTREF, 150);
    level <= 24'sd799;
    wait_upd(2, g);
    chk(disp_value, 32'hFFFFFFFF);
    key(mmu_pkg::K_FUNC, 0);
    chk(32'(status.extref_on), 32'h0);
    chk({29'h0, status.limits_on, status.offset_on, status.scale_on}, 0);
    bus(1'b0, mmu_pkg::A_LIMHI, 0);
    chk(rd, 32'd96);
    bus(1'b0, mmu_pkg::A_SCALE, 0);
    chk(rd, 32'd4);
  endtask

  task automatic t_modes;
    u_far.press(mmu_pkg::K_REMOTE, 10);
    chk(32'(status.remote), 32'h0);
    key(mmu_pkg::K_REMOTE, 0);
    key(mmu_pkg::K_SCALE, 0);
    u_far.press(mmu_pkg::K_OFFSET, 10);
    chk({29'h0, status.remote, status.scale_on, status.offset_on}, 32'h4);
    u_far.press(mmu_pkg::K_REMOTE, 10);
    chk(32'(status.remote), 32'h0);
    key(mmu_pkg::K_FUNC, 32'(mmu_pkg::FN_VAC));
    chk(32'(status.err), 32'(mmu_pkg::ERR_MODULE));
    key(mmu_pkg::K_SCALE, 0);
    @(posedge hclk);
    pin_cal <= 1'b1;
    repeat (6) @(posedge hclk);
    chk({status.err, status.extra_digit, status.show_ovr, status.scale_on}, 32'h4);
    wait_upd(2, g);
    key(mmu_pkg::K_STORE, 0);
    bus(1'b0, mmu_pkg::A_CALF, 0);
    chk(rd, 32'd800);
    @(posedge hclk);
    pin_cal <= 1'b0;
    key(mmu_pkg::K_FUNC, 0);
    key(mmu_pkg::K_REMOTE, 0);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk(32'(status.remote), 32'h0);
    bus(1'b0, mmu_pkg::A_PKHI, 0);
    chk(rd, 32'h0);
    bus(1'b0, mmu_pkg::A_SCALE, 0);
    chk(rd, 32'h1);
  endtask

  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pin_cal = 1'b0;
    level = 24'sd399;
    num_errors = 0;
    comparisons = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_keys();
    t_filter();
    t_peak();
    t_math();
    t_modes();
    wrap_up();
  end
endmodule
`default_nettype wire
